// file: aar_consts.svh
// constants for the acyclic attribute responder
`ifndef AAR_CONSTS_SVH
`define AAR_CONSTS_SVH

// status codes returned per request
`define AAR_ST_SUCCESS       8'h00
`define AAR_ST_PATH_UNKNOWN  8'h05
`define AAR_ST_SVC_UNSUPP    8'h08
`define AAR_ST_BAD_VALUE     8'h09
`define AAR_ST_NOT_SETTABLE  8'h0e
`define AAR_ST_ATTR_UNSUPP   8'h14
`define AAR_ST_NO_OBJECT     8'h16

// service codes
`define AAR_SVC_SET_SINGLE   8'h10
`define AAR_SVC_GET_SINGLE   8'h0e

// vendor object classes
`define AAR_CLASS_FIRST      8'h64
`define AAR_CLASS_LAST       8'h68
`define AAR_CLASS_STATUS     8'h67
`define AAR_CLASS_INFO       8'h68

// the only attribute number served
`define AAR_ATTR_VALUE       8'h64

// status object instances carrying the trip code
`define AAR_INST_TRIP_WARN   8'h73
`define AAR_INST_TRIP_CODE   8'h85

// trip code encoding
`define AAR_TRIP_NONE        8'h00
`define AAR_TRIP_CNT         29
`define AAR_TRIP_W           8
// entry 0 is highest priority, packed low entry in low bits
`define AAR_TRIP_TABLE { \
  8'h7a, 8'h79, 8'h77, 8'h76, 8'h75, 8'h74, 8'h73, 8'h72, 8'h71, 8'h68, \
  8'h66, 8'h65, 8'h4b, 8'h46, 8'h3e, 8'h3d, 8'h3c, 8'h37, 8'h36, 8'h32, \
  8'h1d, 8'h1c, 8'h1a, 8'h19, 8'h18, 8'h17, 8'h15, 8'h14, 8'h0b }

`endif

// file: aar_map_model.sv
// behavioural backing store standing in for the starter's mapped registers
`timescale 1ns/1ps
module aar_map_model
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // map port from the responder
  input  wire logic        map_rd,
  input  wire logic        map_wr,
  input  wire logic [15:0] map_addr,
  input  wire logic [15:0] map_wdata,
  input  wire logic        slow,
  output logic             map_ack,
  output logic             map_absent,
  output logic             map_read_only,
  output logic [15:0]      map_limit,
  output logic [15:0]      map_rdata
);
  logic [15:0] mem_q [0:255];
  logic [1:0]  wait_q;
  logic        tog_q;
  logic        strobe;
  assign strobe = map_rd | map_wr;
  // slow mode holds the ack off for three cycles
  assign map_ack = strobe && (!slow || wait_q == 2'h3);
  // outside an ack the answer lines toggle, so a stale value is never seen
  assign map_absent    = map_ack ? (map_addr[7:0] == 8'h65) : tog_q;
  assign map_read_only = map_ack ? (map_addr[7:0] == 8'h66) : tog_q;
  assign map_limit     = map_ack ? 16'h00ff : {16{tog_q}};
  assign map_rdata     = map_ack ? mem_q[map_addr[7:0]] : {16{tog_q}};
  initial
  begin
    foreach (mem_q[i]) mem_q[i] = {8'h5a, i[7:0]};
  end
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wait_q <= 2'h0;
      tog_q  <= 1'b0;
    end
    else
    begin
      tog_q  <= ~tog_q;
      wait_q <= (strobe && !map_ack) ? wait_q + 2'h1 : 2'h0;
    end
  end
  always @(posedge core_clk)
  begin
    if (map_ack && map_wr) mem_q[map_addr[7:0]] <= map_wdata;
  end
endmodule

// file: aar_pkg.sv
// types for the acyclic attribute responder
package aar_pkg;
  typedef enum logic [2:0] {
    AAR_IDLE,
    AAR_CHECK,
    AAR_READ,
    AAR_WRITE,
    AAR_RESP
  } aar_state_t;
endpackage

// file: aar_responder.sv
// acyclic get/set attribute responder with pass-through switch
`timescale 1ns/1ps
`include "aar_consts.svh"
module aar_responder
  import aar_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // request from the network controller
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [7:0]  req_service,
  input  wire logic [7:0]  req_class,
  input  wire logic [7:0]  req_instance,
  input  wire logic [7:0]  req_attr,
  input  wire logic [15:0] req_wdata,
  // response to the network controller
  output logic             rsp_valid,
  output logic [7:0]       rsp_status,
  output logic [15:0]      rsp_rdata,
  // mapped starter registers
  output logic             map_rd,
  output logic             map_wr,
  output logic [15:0]      map_addr,
  output logic [15:0]      map_wdata,
  input  wire logic        map_ack,
  input  wire logic        map_absent,
  input  wire logic        map_read_only,
  input  wire logic [15:0] map_limit,
  input  wire logic [15:0] map_rdata,
  // trip causes from the starter
  input  wire logic [28:0] trip_flags,
  output logic [7:0]       trip_code,
  // switch ports and power
  input  wire logic        ctrl_power_ok,
  input  wire logic        p0_rx_valid,
  input  wire logic [7:0]  p0_rx_data,
  input  wire logic        p1_rx_valid,
  input  wire logic [7:0]  p1_rx_data,
  output logic             p0_tx_valid,
  output logic [7:0]       p0_tx_data,
  output logic             p1_tx_valid,
  output logic [7:0]       p1_tx_data,
  // link status from the phy
  input  wire logic        phy_link_up,
  input  wire logic        phy_speed_100,
  input  wire logic        phy_crossed,
  output logic             link_up,
  output logic             link_speed_100,
  output logic             link_full_duplex,
  output logic             link_mdix,
  // ring
  input  wire logic        ring_beacon,
  output logic             ring_node_active
);
  aar_state_t  state_q;
  logic [7:0]  svc_q;
  logic [7:0]  cls_q;
  logic [7:0]  inst_q;
  logic [7:0]  attr_q;
  logic [15:0] wdata_q;
  logic [7:0]  status_q;
  logic [15:0] rdata_q;
  logic        is_set;
  logic        is_get;
  logic        cls_ok;
  logic        trip_inst;
  logic [7:0]  pre_status;

  aar_trip_if trip_bus ();

  aar_trip_enc u_trip_enc (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .trip     (trip_bus.enc)
  );

  assign trip_bus.flags = trip_flags;
  assign trip_code      = trip_bus.code;

  assign is_set    = (svc_q == `AAR_SVC_SET_SINGLE);
  assign is_get    = (svc_q == `AAR_SVC_GET_SINGLE);
  assign cls_ok    = (cls_q >= `AAR_CLASS_FIRST) && (cls_q <= `AAR_CLASS_LAST);
  assign trip_inst = (cls_q == `AAR_CLASS_STATUS)
                   && ((inst_q == `AAR_INST_TRIP_WARN) || (inst_q == `AAR_INST_TRIP_CODE));

  always_comb
  begin
    if (!cls_ok)
      pre_status = `AAR_ST_NO_OBJECT;
    else if (!is_set && !is_get)
      pre_status = `AAR_ST_SVC_UNSUPP;
    else if (attr_q != `AAR_ATTR_VALUE)
      pre_status = `AAR_ST_ATTR_UNSUPP;
    // info class and the two trip instances of the status class never take writes
    else if (is_set && ((cls_q == `AAR_CLASS_INFO) || trip_inst))
      pre_status = `AAR_ST_NOT_SETTABLE;
    else
      pre_status = `AAR_ST_SUCCESS;
  end

  assign req_ready = (state_q == AAR_IDLE);

  // request sequencing
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q  <= AAR_IDLE;
      svc_q    <= 8'h00;
      cls_q    <= 8'h00;
      inst_q   <= 8'h00;
      attr_q   <= 8'h00;
      wdata_q  <= 16'h0000;
      status_q <= `AAR_ST_SUCCESS;
      rdata_q  <= 16'h0000;
    end
    else
    begin
      case (state_q)
        AAR_IDLE:
        begin
          if (req_valid)
          begin
            svc_q   <= req_service;
            cls_q   <= req_class;
            inst_q  <= req_instance;
            attr_q  <= req_attr;
            wdata_q <= req_wdata;
            state_q <= AAR_CHECK;
          end
        end
        AAR_CHECK:
        begin
          rdata_q <= 16'h0000;
          if (pre_status != `AAR_ST_SUCCESS)
          begin
            status_q <= pre_status;
            state_q  <= AAR_RESP;
          end
          else if (trip_inst)
          begin
            status_q <= `AAR_ST_SUCCESS;
            rdata_q  <= {8'h00, trip_bus.code};
            state_q  <= AAR_RESP;
          end
          else
            state_q <= AAR_READ;
        end
        AAR_READ:
        begin
          if (map_ack)
          begin
            if (map_absent)
            begin
              status_q <= `AAR_ST_PATH_UNKNOWN;
              state_q  <= AAR_RESP;
            end
            else if (is_get)
            begin
              status_q <= `AAR_ST_SUCCESS;
              rdata_q  <= map_rdata;
              state_q  <= AAR_RESP;
            end
            else if (map_read_only)
            begin
              status_q <= `AAR_ST_NOT_SETTABLE;
              state_q  <= AAR_RESP;
            end
            else if (wdata_q > map_limit)
            begin
              status_q <= `AAR_ST_BAD_VALUE;
              state_q  <= AAR_RESP;
            end
            else
              state_q <= AAR_WRITE;
          end
        end
        AAR_WRITE:
        begin
          if (map_ack)
          begin
            status_q <= `AAR_ST_SUCCESS;
            state_q  <= AAR_RESP;
          end
        end
        AAR_RESP:
          state_q <= AAR_IDLE;
        default:
          state_q <= AAR_IDLE;
      endcase
    end
  end

  // mapped register strobes hold until acknowledged
  assign map_rd    = (state_q == AAR_READ);
  assign map_wr    = (state_q == AAR_WRITE);
  assign map_addr  = {cls_q, inst_q};
  assign map_wdata = wdata_q;

  assign rsp_valid  = (state_q == AAR_RESP);
  assign rsp_status = status_q;
  assign rsp_rdata  = rdata_q;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      p0_tx_valid <= 1'b0;
      p0_tx_data  <= 8'h00;
      p1_tx_valid <= 1'b0;
      p1_tx_data  <= 8'h00;
    end
    else
    begin
      p1_tx_valid <= p0_rx_valid & ctrl_power_ok;
      p1_tx_data  <= p0_rx_data;
      p0_tx_valid <= p1_rx_valid & ctrl_power_ok;
      p0_tx_data  <= p1_rx_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link_up        <= 1'b0;
      link_speed_100 <= 1'b0;
      link_mdix      <= 1'b0;
    end
    else
    begin
      link_up        <= phy_link_up;
      link_speed_100 <= phy_link_up & phy_speed_100;
      link_mdix      <= phy_link_up & phy_crossed;
    end
  end

  // half duplex is never offered
  assign link_full_duplex = 1'b1;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      ring_node_active <= 1'b0;
    else
      ring_node_active <= ring_beacon & ctrl_power_ok & phy_link_up;
  end

  sequence s_take;
    req_valid && req_ready;
  endsequence

  // counted from the check cycle, so an early error answer lands on the first step
  sequence s_answer;
    ##[1:40] rsp_valid;
  endsequence

  a_bad_class_status: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_q == AAR_CHECK && !cls_ok |=> rsp_valid && rsp_status == `AAR_ST_NO_OBJECT)
    else $error("unknown class not answered 0x16");

  a_bad_service_status: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_q == AAR_CHECK && cls_ok && !is_set && !is_get |=> rsp_status == `AAR_ST_SVC_UNSUPP)
    else $error("unsupported service not answered 0x08");

  a_bad_attr_status: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_q == AAR_CHECK && cls_ok && (is_set || is_get) && attr_q != `AAR_ATTR_VALUE
    |=> rsp_status == `AAR_ST_ATTR_UNSUPP)
    else $error("unsupported attribute not answered 0x14");

  a_absent_reg_status: assert property (@(posedge core_clk) disable iff (!rst_n)
    map_rd && map_ack && map_absent |=> rsp_valid && rsp_status == `AAR_ST_PATH_UNKNOWN)
    else $error("absent register not answered 0x05");

  a_range_no_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    map_rd && map_ack && !map_absent && is_set && !map_read_only && wdata_q > map_limit
    |=> !map_wr && rsp_status == `AAR_ST_BAD_VALUE)
    else $error("out of range value applied or misreported");

  a_read_only_nowrite: assert property (@(posedge core_clk) disable iff (!rst_n)
    map_rd && map_ack && !map_absent && is_set && map_read_only
    |=> !map_wr && rsp_status == `AAR_ST_NOT_SETTABLE)
    else $error("read-only register written or misreported");

  a_get_success: assert property (@(posedge core_clk) disable iff (!rst_n)
    map_rd && map_ack && !map_absent && is_get
    |=> rsp_valid && rsp_status == `AAR_ST_SUCCESS && rsp_rdata == $past(map_rdata))
    else $error("get did not return data with 0x00");

  a_one_answer: assert property (@(posedge core_clk) disable iff (!rst_n)
    rsp_valid |=> !rsp_valid)
    else $error("more than one answer per request");

  a_trip_readback: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_q == AAR_CHECK && pre_status == `AAR_ST_SUCCESS && trip_inst
    |=> rsp_rdata == {8'h00, $past(trip_bus.code)})
    else $error("trip code not returned");

  a_switch_power: assert property (@(posedge core_clk) disable iff (!rst_n)
    !ctrl_power_ok |=> !p0_tx_valid && !p1_tx_valid)
    else $error("frame forwarded without control power");

  a_class_answer: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_take ##1 (cls_ok && attr_q == `AAR_ATTR_VALUE && is_get && !trip_inst) |-> ##1 map_rd)
    else $error("vendor class request not served");

  a_request_bounded: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_take ##1 !cls_ok |-> s_answer)
    else $error("request not answered in time");
endmodule

// file: aar_responder_tb.sv
// self-checking testbench for the attribute responder
`timescale 1ns/1ps
`include "aar_consts.svh"
module aar_responder_tb;
  logic core_clk, rst_n, req_valid, req_ready, rsp_valid, map_rd, map_wr, map_ack, map_absent, map_read_only;
  logic [7:0]  req_service, req_class, req_instance, req_attr, rsp_status, trip_code, p0_rx_data, p1_rx_data;
  logic [7:0]  p0_tx_data, p1_tx_data;
  logic [15:0] req_wdata, rsp_rdata, map_addr, map_wdata, map_limit, map_rdata;
  logic [28:0] trip_flags;
  logic ctrl_power_ok, p0_rx_valid, p1_rx_valid, p0_tx_valid, p1_tx_valid, phy_link_up, phy_speed_100;
  logic phy_crossed, link_up, link_speed_100, link_full_duplex, link_mdix, ring_beacon, ring_node_active, slow;
  int failures, checks_done;
  logic [7:0] trip_exp [29] = '{8'h0b, 8'h14, 8'h15, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h1c, 8'h1d, 8'h32, 8'h36,
    8'h37, 8'h3c, 8'h3d, 8'h3e, 8'h46, 8'h4b, 8'h65, 8'h66, 8'h68, 8'h71, 8'h72, 8'h73, 8'h74, 8'h75, 8'h76,
    8'h77, 8'h79, 8'h7a};
  localparam logic [7:0] GET = `AAR_SVC_GET_SINGLE;
  localparam logic [7:0] SET = `AAR_SVC_SET_SINGLE;
  localparam logic [7:0] ATR = `AAR_ATTR_VALUE;

  aar_responder DUT (.core_clk, .rst_n, .req_valid, .req_ready, .req_service, .req_class, .req_instance,
    .req_attr, .req_wdata, .rsp_valid, .rsp_status, .rsp_rdata, .map_rd, .map_wr, .map_addr, .map_wdata,
    .map_ack, .map_absent, .map_read_only, .map_limit, .map_rdata, .trip_flags, .trip_code, .ctrl_power_ok,
    .p0_rx_valid, .p0_rx_data, .p1_rx_valid, .p1_rx_data, .p0_tx_valid, .p0_tx_data, .p1_tx_valid,
    .p1_tx_data, .phy_link_up, .phy_speed_100, .phy_crossed, .link_up, .link_speed_100, .link_full_duplex,
    .link_mdix, .ring_beacon, .ring_node_active);
  aar_map_model store (.core_clk, .rst_n, .map_rd, .map_wr, .map_addr, .map_wdata, .slow, .map_ack,
    .map_absent, .map_read_only, .map_limit, .map_rdata);

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one request, held a single cycle since ready is high in idle
  task automatic xact(input logic [7:0] svc, input logic [7:0] cls, input logic [7:0] inst,
                      input logic [7:0] attr, input logic [15:0] wd, input logic [7:0] est,
                      input logic [15:0] erd);
    int n;
    @(negedge core_clk);
    chk({15'h0000, req_ready}, 16'h0001);
    req_service  = svc;
    req_class    = cls;
    req_instance = inst;
    req_attr     = attr;
    req_wdata    = wd;
    req_valid    = 1'b1;
    @(negedge core_clk);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 40)
    begin
      @(negedge core_clk);
      n++;
    end
    chk({15'h0000, rsp_valid}, 16'h0001);
    chk({8'h00, rsp_status}, {8'h00, est});
    chk(rsp_rdata, erd);
  endtask

  task automatic t_errors();
    xact(GET, 8'h63, 8'h10, ATR, 16'h0000, `AAR_ST_NO_OBJECT, 16'h0000);
    xact(GET, 8'h69, 8'h10, ATR, 16'h0000, `AAR_ST_NO_OBJECT, 16'h0000);
    xact(8'h01, 8'h64, 8'h10, ATR, 16'h0000, `AAR_ST_SVC_UNSUPP, 16'h0000);
    xact(GET, 8'h64, 8'h10, 8'h65, 16'h0000, `AAR_ST_ATTR_UNSUPP, 16'h0000);
    xact(8'h01, 8'h63, 8'h10, 8'h65, 16'h0000, `AAR_ST_NO_OBJECT, 16'h0000);
    xact(8'h01, 8'h64, 8'h10, 8'h65, 16'h0000, `AAR_ST_SVC_UNSUPP, 16'h0000);
  endtask

  task automatic t_setget();
    for (int c = 0; c < 4; c++)
    begin
      xact(SET, 8'h64 + c[7:0], 8'h10 + c[7:0], ATR, 16'h0040 + c[15:0], `AAR_ST_SUCCESS, 16'h0000);
      xact(GET, 8'h64 + c[7:0], 8'h10 + c[7:0], ATR, 16'h0000, `AAR_ST_SUCCESS, 16'h0040 + c[15:0]);
    end
    xact(GET, 8'h68, 8'h13, ATR, 16'h0000, `AAR_ST_SUCCESS, 16'h0043);
    xact(SET, 8'h68, 8'h13, ATR, 16'h0001, `AAR_ST_NOT_SETTABLE, 16'h0000);
  endtask

  // slow store: the limit edge and one past it
  task automatic t_range();
    slow = 1'b1;
    xact(SET, 8'h64, 8'h10, ATR, 16'h0100, `AAR_ST_BAD_VALUE, 16'h0000);
    xact(GET, 8'h64, 8'h10, ATR, 16'h0000, `AAR_ST_SUCCESS, 16'h0040);
    xact(SET, 8'h64, 8'h10, ATR, 16'h00ff, `AAR_ST_SUCCESS, 16'h0000);
    xact(GET, 8'h64, 8'h10, ATR, 16'h0000, `AAR_ST_SUCCESS, 16'h00ff);
    slow = 1'b0;
  endtask

  task automatic t_ro_absent();
    xact(SET, 8'h65, 8'h66, ATR, 16'h1234, `AAR_ST_NOT_SETTABLE, 16'h0000);
    xact(GET, 8'h65, 8'h66, ATR, 16'h0000, `AAR_ST_SUCCESS, 16'h5a66);
    xact(GET, 8'h65, 8'h65, ATR, 16'h0000, `AAR_ST_PATH_UNKNOWN, 16'h0000);
    xact(SET, 8'h65, 8'h65, ATR, 16'h0001, `AAR_ST_PATH_UNKNOWN, 16'h0000);
  endtask

  // all causes from bit i upward set, so the lowest one must win
  task automatic t_trip();
    for (int i = 0; i < 29; i++)
    begin
      @(negedge core_clk);
      trip_flags = {29{1'b1}} << i;
      @(negedge core_clk);
      chk({8'h00, trip_code}, {8'h00, trip_exp[i]});
      if (i == 4) xact(GET, `AAR_CLASS_STATUS, `AAR_INST_TRIP_WARN, ATR, 16'h0000, 8'h00, 16'h0018);
    end
    xact(GET, `AAR_CLASS_STATUS, `AAR_INST_TRIP_CODE, ATR, 16'h0000, 8'h00, 16'h007a);
    xact(SET, `AAR_CLASS_STATUS, `AAR_INST_TRIP_CODE, ATR, 16'h0000, `AAR_ST_NOT_SETTABLE, 16'h0000);
    trip_flags = '0;
    @(negedge core_clk);
    @(negedge core_clk);
    chk({8'h00, trip_code}, 16'h0000);
  endtask

  task automatic t_switch();
    @(negedge core_clk);
    {p0_rx_valid, p0_rx_data, p1_rx_valid, p1_rx_data} = {1'b1, 8'ha5, 1'b1, 8'h3c};
    @(negedge core_clk);
    chk({7'h00, p1_tx_valid, p1_tx_data}, 16'h01a5);
    chk({7'h00, p0_tx_valid, p0_tx_data}, 16'h013c);
    ctrl_power_ok = 1'b0;
    @(negedge core_clk);
    chk({14'h0000, p1_tx_valid, p0_tx_valid}, 16'h0000);
    {p0_rx_valid, p1_rx_valid, ctrl_power_ok} = 3'h1;
  endtask

  task automatic t_link();
    @(negedge core_clk);
    {phy_link_up, phy_speed_100, phy_crossed, ring_beacon} = 4'hf;
    @(negedge core_clk);
    chk({12'h000, link_up, link_speed_100, link_full_duplex, link_mdix}, 16'h000f);
    chk({15'h0000, ring_node_active}, 16'h0001);
    {phy_link_up, phy_speed_100, phy_crossed} = 3'h2;
    @(negedge core_clk);
    chk({12'h000, link_up, link_speed_100, link_full_duplex, link_mdix}, 16'h0002);
    chk({15'h0000, ring_node_active}, 16'h0000);
  endtask

  initial
  begin
    {rst_n, req_valid, req_service, req_class, req_instance, req_attr, req_wdata} = '0;
    {trip_flags, p0_rx_valid, p0_rx_data, p1_rx_valid, p1_rx_data, slow} = '0;
    {phy_link_up, phy_speed_100, phy_crossed, ring_beacon} = 4'h0;
    ctrl_power_ok = 1'b1;
    failures      = 0;
    checks_done   = 0;
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    t_errors();
    t_setget();
    t_range();
    t_ro_absent();
    t_trip();
    t_switch();
    t_link();
    wrap_up();
  end

  // the whole run needs well under a thousand cycles
  initial
  begin
    #(50 * 20000);
    failures++;
    wrap_up();
  end
endmodule

// file: aar_trip_enc.sv
// priority encoder from trip cause flags to numeric trip code
`timescale 1ns/1ps
`include "aar_consts.svh"
module aar_trip_enc
  import aar_pkg::*;
(
  // clock and reset
  input wire logic     core_clk,
  input wire logic     rst_n,
  // trip causes in, code out
  aar_trip_if.enc      trip
);
  localparam logic [`AAR_TRIP_CNT*`AAR_TRIP_W-1:0] TABLE = `AAR_TRIP_TABLE;

  logic [`AAR_TRIP_CNT-1:0] hit;
  logic [`AAR_TRIP_W-1:0]   part [`AAR_TRIP_CNT];
  logic [`AAR_TRIP_W-1:0]   code_d;
  logic [`AAR_TRIP_W-1:0]   code_q;

  // lowest entry wins when several causes are active
  genvar i;
  generate
    for (i = 0; i < `AAR_TRIP_CNT; i++)
    begin : g_entry
      if (i == 0)
      begin : g_first
        assign hit[i] = trip.flags[i];
      end
      else
      begin : g_rest
        assign hit[i] = trip.flags[i] & ~(|trip.flags[i-1:0]);
      end
      assign part[i] = hit[i] ? TABLE[i*`AAR_TRIP_W +: `AAR_TRIP_W] : `AAR_TRIP_NONE;
    end
  endgenerate

  always_comb
  begin
    code_d = `AAR_TRIP_NONE;
    for (int k = 0; k < `AAR_TRIP_CNT; k++)
      code_d = code_d | part[k];
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      code_q <= `AAR_TRIP_NONE;
    else
      code_q <= code_d;
  end

  assign trip.code    = code_q;
  assign trip.tripped = (code_q != `AAR_TRIP_NONE);

  // a_no_trip_zero: zero code when idle
  a_no_trip_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(trip.flags) == '0 |-> code_q == `AAR_TRIP_NONE)
    else $error("trip code not zero without cause");
endmodule

// file: aar_trip_if.sv
// carrier between the responder and its trip encoder
`timescale 1ns/1ps
`include "aar_consts.svh"
interface aar_trip_if;
  logic [`AAR_TRIP_CNT-1:0] flags;
  logic [`AAR_TRIP_W-1:0]   code;
  logic                     tripped;
  modport enc  (input flags, output code, output tripped);
  modport user (output flags, input code, input tripped);
endinterface
